// file: verilog/pmc_regs.vh
// Purpose: register map, field positions, encodings and timing counts
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   included by every design file of the mode controller
`ifndef PMC_REGS_VH
`define PMC_REGS_VH

// register byte offsets
`define PMC_CTRL_OFS        12'h000
`define PMC_STAT_OFS        12'h004
`define PMC_WAKE_EN_OFS     12'h008
`define PMC_SWITCH_OFS      12'h00c

// control register fields
`define PMC_CTRL_SLEEP      0
`define PMC_CTRL_RETAIN     1
`define PMC_CTRL_LPM        2
`define PMC_CTRL_RESET      32'h0000_0000

// status register fields
`define PMC_STAT_MODE_LSB   0
`define PMC_STAT_BROWNOUT   4
`define PMC_STAT_UNDERVOLT  5
`define PMC_STAT_MAIN_OK    6
`define PMC_STAT_BAT_OK     7
`define PMC_STAT_WAKE_SEQ   8

// wake enable reset value
`define PMC_WAKE_EN_RESET   8'h00

// operating mode codes
`define PMC_MODE_MISSION    3'h0
`define PMC_MODE_BROWNOUT   3'h1
`define PMC_MODE_DISPLAY    3'h2
`define PMC_MODE_SLEEP      3'h3
`define PMC_MODE_LPM        3'h4
`define PMC_MODE_WAKE       3'h5

// supply source codes for the selectors
`define PMC_SRC_OFF         2'h0
`define PMC_SRC_MAIN        2'h1
`define PMC_SRC_BAT         2'h2
`define PMC_SRC_BACKUP      2'h3

// watchdog intervals in milliseconds and the enable divider
`define PMC_WDT_NORMAL_MS   1500
`define PMC_WDT_LPM_MS      6000
`define PMC_CLK_HZ          125000000
`define PMC_TICK_CYCLES     125000

// wake sequence length in pclk cycles
`define PMC_WAKE_CYCLES     8'h10

`endif

// file: verilog/pmc_tick.v
// Purpose: divider making a one-cycle millisecond enable from pclk
// Assumes: pclk at the rate given in the header
// Notes:   the period is a parameter so a simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_tick #(
  parameter [31:0] TICK_CYCLES = `PMC_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  output reg         tick
);

  reg [31:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_q >= TICK_CYCLES - 32'h0000_0001) begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end

endmodule // pmc_tick

`default_nettype wire

// file: verilog/pmc_watchdog.v
// Purpose: watchdog timer with a normal and an extended interval
// Assumes: tick is a one-cycle millisecond enable
// Notes:   kick restarts the count; expired is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_watchdog (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        tick,
  input  wire        enable,
  input  wire        kick,
  input  wire        extended,
  output reg         expired,
  output wire [12:0] interval_ms
);

  reg [12:0] cnt_q;

  assign interval_ms = extended ? 13'd`PMC_WDT_LPM_MS
                                : 13'd`PMC_WDT_NORMAL_MS;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 13'h0000;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!enable || kick) begin
        cnt_q <= 13'h0000;
      end else if (tick) begin
        if (cnt_q + 13'h0001 >= interval_ms) begin
          cnt_q   <= 13'h0000;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 13'h0001;
        end
      end
    end
  end

endmodule // pmc_watchdog

`default_nettype wire

// file: verilog/pmc_mode_ctrl.v
// Purpose: power mode sequencer and supply switch control
// Assumes: comparator levels are synchronous to pclk
// Notes:   registers reached over apb, zero wait states
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"

module pmc_mode_ctrl #(
  parameter [31:0] TICK_CYCLES = `PMC_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        main_supply_ok,
  input  wire        battery_ok,
  input  wire        battery_undervolt,
  input  wire [7:0]  wake_events,
  input  wire        wdt_kick,
  output reg  [1:0]  io_core_switch,
  output reg  [1:0]  analog_switch,
  output reg         display_switch,
  output reg  [1:0]  calibration_source_switch,
  output reg  [1:0]  oscillator_source_switch,
  output reg         calibration_isolate_switch,
  output reg         core_run,
  output reg         core_regulator_en,
  output reg         io_core_domain_on,
  output reg         analog_domain_on,
  output reg         display_domain_on,
  output reg         wdt_reset
);

  ////////////////////////////////////////////////////////////////////////
  // state

  reg        sleep_bit_q;
  reg        display_retain_bit_q;
  reg        low_power_metering_bit_q;
  reg        battery_undervoltage_flag_q;
  reg        brownout_flag_q;
  reg [7:0]  wake_en_q;
  reg [2:0]  mode_q;
  reg [2:0]  mode_d;
  reg [7:0]  wake_cnt_q;
  reg [31:0] rdata_q;

  wire       tick;
  wire       wdt_expired;
  wire [12:0] wdt_interval;
  wire       wake_pending = |(wake_events & wake_en_q);
  wire       low_power_metering = (mode_q == `PMC_MODE_LPM);

  function [2:0] awake_mode;
    input main_ok;
    begin
      awake_mode = main_ok ? `PMC_MODE_MISSION : `PMC_MODE_BROWNOUT;
    end
  endfunction

  // true in the two modes that take io, core and regulator down
  function core_down;
    input [2:0] mode;
    begin
      core_down = (mode == `PMC_MODE_DISPLAY) ||
                  (mode == `PMC_MODE_SLEEP);
    end
  endfunction

  // calibration bus source by priority of the good supplies
  function [1:0] cal_source;
    input main_ok;
    input bat_ok;
    begin
      if (main_ok)
        cal_source = `PMC_SRC_MAIN;
      else if (bat_ok)
        cal_source = `PMC_SRC_BAT;
      else
        cal_source = `PMC_SRC_BACKUP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb slave

  wire wr_en = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite;
  wire ctrl_wr = wr_en & (paddr == `PMC_CTRL_OFS);
  wire stat_wr = wr_en & (paddr == `PMC_STAT_OFS);
  wire mapped = (paddr == `PMC_CTRL_OFS) | (paddr == `PMC_STAT_OFS) |
                (paddr == `PMC_WAKE_EN_OFS) | (paddr == `PMC_SWITCH_OFS);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = rdata_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        `PMC_CTRL_OFS:
          rdata_q <= {29'h0000_0000, low_power_metering_bit_q,
                      display_retain_bit_q, sleep_bit_q};
        `PMC_STAT_OFS:
          rdata_q <= {23'h00_0000, (mode_q == `PMC_MODE_WAKE),
                      battery_ok, main_supply_ok,
                      battery_undervoltage_flag_q, brownout_flag_q,
                      1'b0, mode_q};
        `PMC_WAKE_EN_OFS:
          rdata_q <= {24'h00_0000, wake_en_q};
        `PMC_SWITCH_OFS:
          rdata_q <= {19'h0_0000, wdt_interval};
        default:
          rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits and sticky flags

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_bit_q              <= 1'b0;
      display_retain_bit_q     <= 1'b0;
      low_power_metering_bit_q <= 1'b0;
      wake_en_q                <= `PMC_WAKE_EN_RESET;
    end else begin
      if (ctrl_wr) begin
        sleep_bit_q              <= pwdata[`PMC_CTRL_SLEEP];
        display_retain_bit_q     <= pwdata[`PMC_CTRL_RETAIN];
        low_power_metering_bit_q <= pwdata[`PMC_CTRL_LPM];
      end
      if (wr_en && paddr == `PMC_WAKE_EN_OFS)
        wake_en_q <= pwdata[7:0];
      // wake done clears the sleep request
      if (mode_q == `PMC_MODE_WAKE && wake_cnt_q == 8'h00)
        sleep_bit_q <= 1'b0;
      // forced sleep on undervoltage; comes last so it beats the clear
      if (mode_q != `PMC_MODE_SLEEP && battery_undervolt &&
          !main_supply_ok)
        sleep_bit_q <= 1'b1;
    end
  end

  // flags clear by writing one; a new event in the same cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_undervoltage_flag_q <= 1'b0;
      brownout_flag_q             <= 1'b0;
    end else begin
      if (battery_undervolt && !main_supply_ok &&
          mode_q != `PMC_MODE_SLEEP)
        battery_undervoltage_flag_q <= 1'b1;
      else if (stat_wr && pwdata[`PMC_STAT_UNDERVOLT])
        battery_undervoltage_flag_q <= 1'b0;
      if (mode_q == `PMC_MODE_MISSION && !main_supply_ok)
        brownout_flag_q <= 1'b1;
      else if (stat_wr && pwdata[`PMC_STAT_BROWNOUT])
        brownout_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode sequencer

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      `PMC_MODE_MISSION, `PMC_MODE_BROWNOUT: begin
        if (sleep_bit_q && low_power_metering_bit_q)
          mode_d = `PMC_MODE_LPM;
        else if (sleep_bit_q && display_retain_bit_q)
          mode_d = `PMC_MODE_DISPLAY;
        else if (sleep_bit_q)
          mode_d = `PMC_MODE_SLEEP;
        else
          mode_d = awake_mode(main_supply_ok);
      end
      `PMC_MODE_LPM: begin
        if (!sleep_bit_q || !low_power_metering_bit_q)
          mode_d = awake_mode(main_supply_ok);
      end
      // pending wake is seen only after the mode is entered
      `PMC_MODE_DISPLAY: begin
        if (wake_pending)
          mode_d = `PMC_MODE_WAKE;
      end
      `PMC_MODE_SLEEP: begin
        if (wake_pending)
          mode_d = `PMC_MODE_WAKE;
      end
      `PMC_MODE_WAKE: begin
        if (wake_cnt_q == 8'h00)
          mode_d = awake_mode(main_supply_ok);
      end
      default: mode_d = `PMC_MODE_MISSION;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q     <= `PMC_MODE_MISSION;
      wake_cnt_q <= 8'h00;
    end else begin
      mode_q <= mode_d;
      if (mode_d == `PMC_MODE_WAKE && mode_q != `PMC_MODE_WAKE)
        wake_cnt_q <= `PMC_WAKE_CYCLES;
      else if (wake_cnt_q != 8'h00)
        wake_cnt_q <= wake_cnt_q - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // supply switches and domain enables

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_core_switch             <= `PMC_SRC_MAIN;
      analog_switch              <= `PMC_SRC_MAIN;
      display_switch             <= 1'b1;
      calibration_source_switch  <= `PMC_SRC_MAIN;
      oscillator_source_switch   <= `PMC_SRC_MAIN;
      calibration_isolate_switch <= 1'b1;
      core_run                   <= 1'b1;
      core_regulator_en          <= 1'b1;
      io_core_domain_on          <= 1'b1;
      analog_domain_on           <= 1'b1;
      display_domain_on          <= 1'b1;
    end else begin
      // io/core source
      if (core_down(mode_q))
        io_core_switch <= `PMC_SRC_OFF;
      else if (main_supply_ok)
        io_core_switch <= `PMC_SRC_MAIN;
      else
        io_core_switch <= `PMC_SRC_BAT;
      // analog source
      if (main_supply_ok)
        analog_switch <= `PMC_SRC_MAIN;
      else if (sleep_bit_q && low_power_metering_bit_q)
        analog_switch <= `PMC_SRC_BAT;
      else
        analog_switch <= `PMC_SRC_OFF;
      // display from core regulator unless display-only
      display_switch <= (mode_q != `PMC_MODE_DISPLAY);
      // calibration bus priority
      calibration_source_switch <= cal_source(main_supply_ok,
                                              battery_ok);
      oscillator_source_switch <= main_supply_ok ? `PMC_SRC_MAIN
                                                 : `PMC_SRC_BACKUP;
      calibration_isolate_switch <= (mode_q != `PMC_MODE_SLEEP);
      core_run <= (mode_q == `PMC_MODE_MISSION) ||
                  (mode_q == `PMC_MODE_BROWNOUT) ||
                  (mode_q == `PMC_MODE_LPM);
      core_regulator_en <= !core_down(mode_q);
      io_core_domain_on <= !core_down(mode_q);
      analog_domain_on <= main_supply_ok ||
                          (mode_q == `PMC_MODE_LPM);
      display_domain_on <= (mode_q != `PMC_MODE_SLEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog

  pmc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  pmc_watchdog u_wdt (
    .pclk        (pclk),
    .presetn     (presetn),
    .tick        (tick),
    .enable      (core_run),
    .kick        (wdt_kick),
    .extended    (low_power_metering),
    .expired     (wdt_expired),
    .interval_ms (wdt_interval)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wdt_reset <= 1'b0;
    else
      wdt_reset <= wdt_expired;
  end

endmodule // pmc_mode_ctrl

`default_nettype wire

// file: test/pmc_mode_ctrl_checker.sv
// Purpose: port assertions for the power mode controller
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   bound to the design from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       main_supply_ok,
  input wire logic       battery_ok,
  input wire logic       battery_undervolt,
  input wire logic [1:0] io_core_switch,
  input wire logic [1:0] analog_switch,
  input wire logic [1:0] calibration_source_switch,
  input wire logic [1:0] oscillator_source_switch,
  input wire logic       calibration_isolate_switch,
  input wire logic       io_core_domain_on,
  input wire logic       display_domain_on,
  input wire logic       wdt_reset
);
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_main_up;
    main_supply_ok [*2];
  endsequence
  sequence s_main_down;
    !main_supply_ok [*2];
  endsequence
  // main supply falls while running from it
  sequence s_drop;
    io_core_switch == 2'h1 && $fell(main_supply_ok) && !battery_undervolt
    ##1 !main_supply_ok && !battery_undervolt;
  endsequence
  a_osc_main: assert property (
    s_main_up |=> oscillator_source_switch == 2'h1)
    else $error("oscillator bus not on main supply");
  a_osc_backup: assert property (
    s_main_down |=> oscillator_source_switch == 2'h3)
    else $error("oscillator bus not on backup battery");
  a_cal_prio: assert property (
    $stable({main_supply_ok, battery_ok}) |=> calibration_source_switch ==
    ($past(main_supply_ok) ? 2'h1 : ($past(battery_ok) ? 2'h2 : 2'h3)))
    else $error("calibration source priority wrong");
  a_brown_io: assert property (
    s_drop |-> ##[1:2] io_core_switch == 2'h2)
    else $error("io core switch not moved to battery");
  a_iso_sleep: assert property (
    !display_domain_on |-> !calibration_isolate_switch)
    else $error("calibration bus not isolated in sleep");
  a_iso_closed: assert property (
    io_core_domain_on |-> calibration_isolate_switch)
    else $error("calibration bus open while running");
  a_neutral_off: assert property (
    io_core_switch == 2'h0 |-> !io_core_domain_on)
    else $error("io core domain on with neutral switch");
  a_analog_bat: assert property (
    analog_switch == 2'h2 |-> !$past(main_supply_ok) ||
    !$past(main_supply_ok, 2))
    else $error("analog on battery while main supply good");
  a_slverr_phase: assert property (
    pslverr |-> psel && penable && pready)
    else $error("error response outside access phase");
  a_wdt_pulse: assert property (
    wdt_reset |=> !wdt_reset)
    else $error("watchdog reset longer than one cycle");
endmodule // pmc_mode_ctrl_checker
`default_nettype wire

// file: test/pmc_mode_ctrl_tb_top.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: apb answers with no wait states, TICK_CYCLES shortened
// Notes:   random supply levels come from a fixed-seed lfsr
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.vh"
module pmc_mode_ctrl_tb_top;
  localparam int TICK = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        main_supply_ok = 1'b1;
  logic        battery_ok = 1'b1;
  logic        battery_undervolt = 1'b0;
  logic [7:0]  wake_events = 8'h00;
  logic        wdt_kick = 1'b0;
  wire  [31:0] prdata;
  wire         pready, pslverr, display_switch, calibration_isolate_switch;
  wire  [1:0]  io_core_switch, analog_switch;
  wire  [1:0]  calibration_source_switch, oscillator_source_switch;
  wire         core_run, core_regulator_en, io_core_domain_on;
  wire         analog_domain_on, display_domain_on, wdt_reset;
  int          errors = 0;
  int          n_compared = 0;
  logic        saw_a = 1'b0;
  logic        saw_b = 1'b0;
  logic        clr_saw = 1'b0;
  always #4 pclk = ~pclk;
  pmc_mode_ctrl #(.TICK_CYCLES(TICK)) u_dut (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .main_supply_ok             (main_supply_ok),
    .battery_ok                 (battery_ok),
    .battery_undervolt          (battery_undervolt),
    .wake_events                (wake_events),
    .wdt_kick                   (wdt_kick),
    .io_core_switch             (io_core_switch),
    .analog_switch              (analog_switch),
    .display_switch             (display_switch),
    .calibration_source_switch  (calibration_source_switch),
    .oscillator_source_switch   (oscillator_source_switch),
    .calibration_isolate_switch (calibration_isolate_switch),
    .core_run                   (core_run),
    .core_regulator_en          (core_regulator_en),
    .io_core_domain_on          (io_core_domain_on),
    .analog_domain_on           (analog_domain_on),
    .display_domain_on          (display_domain_on),
    .wdt_reset                  (wdt_reset)
  );
  // latch short-lived states seen between register reads
  always @(posedge pclk) begin
    if (clr_saw) begin
      saw_a <= 1'b0;
      saw_b <= 1'b0;
    end else begin
      if (display_switch === 1'b0 && core_regulator_en === 1'b0 &&
          core_run === 1'b0) saw_a <= 1'b1;
      if (io_core_switch === 2'h0 && calibration_isolate_switch === 1'b0)
        saw_b <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [1:0] exp_cal(input logic m, input logic b);
    return m ? `PMC_SRC_MAIN : (b ? `PMC_SRC_BAT : `PMC_SRC_BACKUP);
  endfunction
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) begin
      errors++;
      tally_and_finish;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic st(input logic [2:0] m);
    logic [31:0] q;
    rd(`PMC_STAT_OFS, q);
    chk(q[2:0], m);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [15:0] s;
    logic        e;
    int          n;
    s = 16'd11171;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`PMC_CTRL_OFS, q);
    chk(q, `PMC_CTRL_RESET);
    rd(`PMC_WAKE_EN_OFS, q);
    chk(q, {24'h0, `PMC_WAKE_EN_RESET});
    rd(`PMC_SWITCH_OFS, q);
    chk(q, `PMC_WDT_NORMAL_MS);
    apb(1'b1, 12'h010, 32'hffff_ffff, q, e);
    chk(e, 1'b1);
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0);
    for (int i = 0; i < 12; i++) begin
      s = lfsr(s);
      main_supply_ok <= s[0];
      battery_ok <= s[1];
      wake_events <= s[15:8];
      repeat (4) @(posedge pclk);
      chk(calibration_source_switch, exp_cal(s[0], s[1]));
      chk(oscillator_source_switch, s[0] ? 2'h1 : 2'h3);
    end
    {main_supply_ok, battery_ok, wake_events} <= {2'b11, 8'h00};
    repeat (4) @(posedge pclk);
    st(`PMC_MODE_MISSION);
    chk(display_switch, 1'b1);
    main_supply_ok <= 1'b0;
    repeat (4) @(posedge pclk);
    rd(`PMC_STAT_OFS, q);
    chk(q[4:0], {1'b1, 1'b0, `PMC_MODE_BROWNOUT});
    chk({io_core_switch, analog_switch}, 4'h8);
    chk({core_run, analog_domain_on}, 2'h2);
    wr(`PMC_CTRL_OFS, 32'h5);
    repeat (3) @(posedge pclk);
    st(`PMC_MODE_LPM);
    chk({io_core_domain_on, analog_domain_on, display_domain_on}, 3'h7);
    chk(analog_switch, `PMC_SRC_BAT);
    rd(`PMC_SWITCH_OFS, q);
    chk(q, `PMC_WDT_LPM_MS);
    wr(`PMC_CTRL_OFS, 32'h0);
    wr(`PMC_WAKE_EN_OFS, 32'h1);
    wr(`PMC_CTRL_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    st(`PMC_MODE_SLEEP);
    chk({analog_switch, calibration_isolate_switch}, 3'h0);
    chk({io_core_switch, core_run}, 3'h0);
    wake_events <= 8'h01;
    rd(`PMC_STAT_OFS, q);
    chk(q[8], 1'b1);
    repeat (24) @(posedge pclk);
    st(`PMC_MODE_BROWNOUT);
    rd(`PMC_CTRL_OFS, q);
    chk(q, 32'h0);
    main_supply_ok <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(`PMC_CTRL_OFS, 32'h2);
    clr_saw <= 1'b1;
    @(posedge pclk);
    clr_saw <= 1'b0;
    wr(`PMC_CTRL_OFS, 32'h3);
    repeat (24) @(posedge pclk);
    chk(saw_a, 1'b1);
    st(`PMC_MODE_MISSION);
    rd(`PMC_CTRL_OFS, q);
    chk(q, 32'h2);
    wr(`PMC_CTRL_OFS, 32'h0);
    clr_saw <= 1'b1;
    @(posedge pclk);
    clr_saw <= 1'b0;
    wr(`PMC_CTRL_OFS, 32'h1);
    repeat (24) @(posedge pclk);
    chk(saw_b, 1'b1);
    st(`PMC_MODE_MISSION);
    wake_events <= 8'h00;
    {main_supply_ok, battery_undervolt} <= 2'b01;
    repeat (4) @(posedge pclk);
    rd(`PMC_STAT_OFS, q);
    chk({q[5], q[2:0]}, {1'b1, `PMC_MODE_SLEEP});
    battery_undervolt <= 1'b0;
    wake_events <= 8'h01;
    repeat (24) @(posedge pclk);
    rd(`PMC_STAT_OFS, q);
    chk({q[5], q[2:0]}, {1'b1, `PMC_MODE_BROWNOUT});
    wr(`PMC_STAT_OFS, 32'h20);
    rd(`PMC_STAT_OFS, q);
    chk(q[5], 1'b0);
    {main_supply_ok, wake_events} <= {1'b1, 8'h00};
    repeat (4) @(posedge pclk);
    wdt_kick <= 1'b1;
    @(posedge pclk);
    wdt_kick <= 1'b0;
    n = 0;
    while (wdt_reset !== 1'b1 && n < 1500 * TICK + 40) begin
      n++;
      @(posedge pclk);
    end
    chk(n > 1500 * TICK - 20 && n < 1500 * TICK + 20, 1'b1);
    tally_and_finish;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    tally_and_finish;
  end
endmodule // pmc_mode_ctrl_tb_top
bind pmc_mode_ctrl pmc_mode_ctrl_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .main_supply_ok(main_supply_ok),
  .battery_ok(battery_ok), .battery_undervolt(battery_undervolt),
  .io_core_switch(io_core_switch), .analog_switch(analog_switch),
  .calibration_source_switch(calibration_source_switch),
  .oscillator_source_switch(oscillator_source_switch),
  .calibration_isolate_switch(calibration_isolate_switch),
  .io_core_domain_on(io_core_domain_on),
  .display_domain_on(display_domain_on), .wdt_reset(wdt_reset));
`default_nettype wire
